// >>> pkg/flash_defs.svh
/*
  Constants of the flash command, status and protection block: register
  offsets, field positions, reset values, command codes and the key window.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef FLASH_DEFS_SVH
`define FLASH_DEFS_SVH

// ************************************************************
// register byte offsets on the bus
// ************************************************************
`define OFS_CONFIG 8'h00
`define OFS_PROTECT 8'h04
`define OFS_STATUS 8'h08
`define OFS_COMMAND 8'h0C
`define OFS_CLKDIV 8'h10

// ************************************************************
// field positions
// ************************************************************
`define CFG_KEEP_MASK 8'hE0
`define CFG_KEY_WRITE_SELECT_BIT 5
`define ST_CBE_BIT 7
`define ST_CCF_BIT 6
`define ST_PVIOL_BIT 5
`define ST_ACCERR_BIT 4
`define ST_BLANK_BIT 2
`define DIV_LOADED_BIT 7
`define PROT_DIS_BIT 0

// ************************************************************
// reset values
// ************************************************************
`define CFG_RESET 8'h00
`define PROT_RESET 8'h00
`define DIV_RESET 7'h00

// ************************************************************
// command codes
// ************************************************************
`define CMD_BLANK 8'h05
`define CMD_BYTE_PROG 8'h20
`define CMD_BURST_PROG 8'h25
`define CMD_PAGE_ERASE 8'h40
`define CMD_MASS_ERASE 8'h41

// ************************************************************
// array geometry
// ************************************************************
`define KEY_BASE 16'hFFB0
`define KEY_SPAN 16'h0008
`define PAGE_BITS 9

`endif

// >>> pkg/flash_pkg.sv
/*
  Types of the flash command, status and protection block.
  Assumes the defines header sits beside it on the include path.
*/
`include "flash_defs.svh"

package flash_pkg;

  // command sequence progress
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ADDR,
    SEQ_CMD
  } seq_t;

  // one command as handed to the array engine
  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [7:0] data;
  } eng_req_t;

  // one write to the backdoor key comparison logic
  typedef struct packed {
    logic [2:0] index;
    logic [7:0] data;
  } key_wr_t;

endpackage

// >>> rtl/flash_cmd_status_protect.sv
/*
  Flash command, status and protection registers behind an AHB-Lite slave,
  with the command sequencer and a one-deep burst program buffer.
  Assumes the array engine, key comparator, debug port and stop logic all
  run on hclk; array writes arrive already decoded as one-cycle strobes.
*/
//
// Contract
// R1 - config bits 7:5 rw, 4:0 read zero
// R2 - key clear: key writes start commands
// R3 - key set: compare writes, array reads invalid
// R4 - protect register loaded from stored byte
// R5 - protect ignores bus writes, debug may write
// R6 - select field bounds unprotected low region
// R7 - disable bit turns all protection off
// R8 - status bits 3,1,0 read zero
// R9 - write one to buffer-empty launches command
// R10 - only burst program may be buffered
// R11 - complete flag tracks idle, ignores writes
// R12 - protected target sets violation, drops command
// R13 - access error on sequence, divider, stop
// R14 - blank flag set by clean blank check
// R15 - codes 05, 20, 25 decoded
// R16 - codes 40 page, 41 mass erase
// R17 - other codes raise access error
// R18 - divider write sets loaded, gates program
// R19 - reset leaves empty and complete set
`timescale 1ns/1ps
`include "flash_defs.svh"
module flash_cmd_status_protect
  import flash_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire logic arr_wr, // cpu write to flash array
  input wire logic [15:0] arr_wr_addr, // its address
  input wire logic [7:0] arr_wr_data, // its data
  input wire logic [7:0] stored_protect_byte, // nonvolatile protect copy
  input wire logic dbg_prot_wr, // debug write to protect
  input wire logic [7:0] dbg_prot_data, // debug data
  input wire logic stop_req, // stop mode entry pulse
  input wire logic eng_done, // engine finished command
  input wire logic eng_blank, // blank check found all erased
  output logic eng_start, // start pulse to engine
  output eng_req_t eng_req, // command for engine
  output logic eng_abort, // abort pulse on stop
  output logic key_wr, // key compare write pulse
  output key_wr_t key_wr_info, // key index and byte
  output logic array_read_invalid, // array reads return junk
  output logic [6:0] fclk_div // divider value
);
  // elaboration check: the page select field must stay seven bits wide
  if (ADDR_W - `PAGE_BITS != 7) begin
    $error("ADDR_W must leave a 7-bit page select field");
  end
  // ************************************************************
  // ahb-lite slave front end
  // ************************************************************
  logic wr_pend_r, rd_pend_r, ready_r;
  logic [7:0] wr_addr_r, rd_addr_r;
  logic [31:0] hrdata_r;
  wire logic addr_phase = hsel && htrans[1] && hready;
  wire logic wr_en = wr_pend_r;
  wire logic [7:0] wr_byte = hwdata[7:0];
  // reads get one wait state so back-to-back writes are always visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      ready_r <= 1'b1;
      wr_addr_r <= 8'h00;
      rd_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_phase && hwrite;
      rd_pend_r <= addr_phase && !hwrite;
      ready_r <= !(addr_phase && !hwrite);
      if (addr_phase) begin
        wr_addr_r <= haddr[7:0];
        rd_addr_r <= haddr[7:0];
      end
    end
  end
  // ************************************************************
  // register state
  // ************************************************************
  logic [7:0] cfg_r, cfg_nxt;
  logic [7:0] prot_r, prot_nxt;
  logic prot_loaded_r;
  logic [6:0] div_r, div_nxt;
  logic div_loaded_r, div_loaded_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic pviol_r, pviol_nxt, accerr_r, accerr_nxt, blank_r, blank_nxt;
  seq_t seq_r, seq_nxt;
  eng_req_t pend_r, pend_nxt, buf_r, buf_nxt, req_r, req_nxt;
  logic busy_r, busy_nxt, run_burst_r, run_burst_nxt, buf_full_r, buf_full_nxt;
  logic start_r, start_nxt, abort_r, key_wr_r, hresp_r;
  key_wr_t key_info_r;
  // ************************************************************
  // decode
  // ************************************************************
  wire logic wr_cfg = wr_en && (wr_addr_r == `OFS_CONFIG);
  wire logic wr_stat = wr_en && (wr_addr_r == `OFS_STATUS);
  wire logic wr_cmd = wr_en && (wr_addr_r == `OFS_COMMAND);
  wire logic wr_div = wr_en && (wr_addr_r == `OFS_CLKDIV);
  wire logic key_write_select = cfg_r[`CFG_KEY_WRITE_SELECT_BIT];
  wire logic in_key_win = (arr_wr_addr >= `KEY_BASE) &&
                          (arr_wr_addr < (`KEY_BASE + `KEY_SPAN));
  wire logic key_hit = arr_wr && key_write_select && in_key_win; // R3
  wire logic arr_cmd_wr = arr_wr && !key_hit; // R2
  wire logic cbe = !buf_full_r && (!busy_r || run_burst_r); // R9 R10
  wire logic ccf = !busy_r && !buf_full_r; // R11
  wire logic launch = wr_stat && wr_byte[`ST_CBE_BIT] && cbe; // R9
  wire logic [7:0] lcmd = pend_r.cmd;
  wire logic is_blank = (lcmd == `CMD_BLANK); // R15
  wire logic is_burst = (lcmd == `CMD_BURST_PROG); // R15
  wire logic is_prog = (lcmd == `CMD_BYTE_PROG) || is_burst; // R15
  wire logic is_page = (lcmd == `CMD_PAGE_ERASE); // R16
  wire logic is_mass = (lcmd == `CMD_MASS_ERASE); // R16
  wire logic code_ok = is_blank || is_prog || is_page || is_mass; // R17
  wire logic prog_erase = is_prog || is_page || is_mass;
  wire logic [6:0] tgt_page = pend_r.addr[ADDR_W-1:`PAGE_BITS];
  wire logic prot_on = !prot_r[`PROT_DIS_BIT]; // R7
  // mass erase touches every page, so any active protection blocks it
  wire logic tgt_prot = prot_on && prog_erase &&
                        (is_mass || (tgt_page > prot_r[7:1])); // R6
  wire logic seq_bad = (seq_r != SEQ_CMD) || !prot_loaded_r;
  wire logic div_bad = prog_erase && !div_loaded_r; // R18
  wire logic bad_order = (busy_r && !is_burst) || (busy_r && !run_burst_r);
  wire logic launch_err = launch && (seq_bad || !code_ok || div_bad || bad_order);
  wire logic launch_viol = launch && !launch_err && tgt_prot; // R12
  wire logic launch_ok = launch && !launch_err && !tgt_prot;
  wire logic stop_abort = stop_req && busy_r; // R13
  wire logic seq_break = (arr_cmd_wr && (!cbe || seq_r != SEQ_IDLE)) ||
                         (wr_cmd && seq_r != SEQ_ADDR); // R13
  // ************************************************************
  // control and register next state
  // ************************************************************
  always_comb begin
    cfg_nxt = wr_cfg ? (wr_byte & `CFG_KEEP_MASK) : cfg_r; // R1
    prot_nxt = dbg_prot_wr ? dbg_prot_data : prot_r; // R5
    div_nxt = wr_div ? wr_byte[6:0] : div_r;
    div_loaded_nxt = div_loaded_r || wr_div; // R18
    cmd_nxt = wr_cmd ? wr_byte : cmd_r;
    seq_nxt = seq_r;
    pend_nxt = pend_r;
    buf_nxt = buf_r;
    req_nxt = req_r;
    busy_nxt = busy_r;
    run_burst_nxt = run_burst_r;
    buf_full_nxt = buf_full_r;
    start_nxt = 1'b0;
    blank_nxt = blank_r;
    // clear by writing one; a same-cycle set below wins
    pviol_nxt = pviol_r && !(wr_stat && wr_byte[`ST_PVIOL_BIT]);
    accerr_nxt = accerr_r && !(wr_stat && wr_byte[`ST_ACCERR_BIT]);
    // sequence: array write, then command write, then launch
    unique case (seq_r)
      SEQ_IDLE: begin
        if (arr_cmd_wr && cbe) begin
          seq_nxt = SEQ_ADDR;
          pend_nxt.addr = arr_wr_addr;
          pend_nxt.data = arr_wr_data;
        end
      end
      SEQ_ADDR: begin
        if (wr_cmd) begin
          seq_nxt = SEQ_CMD;
          pend_nxt.cmd = wr_byte;
        end
      end
      SEQ_CMD: begin
        if (launch) begin
          seq_nxt = SEQ_IDLE;
        end
      end
    endcase
    if (seq_break || launch_err) begin
      seq_nxt = SEQ_IDLE; // R13
      accerr_nxt = 1'b1; // R13 R17
    end
    if (launch_viol) begin
      seq_nxt = SEQ_IDLE;
      pviol_nxt = 1'b1; // R12
    end
    // engine completion: blank result, then buffered burst moves on
    if (eng_done && busy_r) begin
      if (req_r.cmd == `CMD_BLANK && eng_blank) begin
        blank_nxt = 1'b1; // R14
      end
      if (buf_full_r) begin
        req_nxt = buf_r;
        start_nxt = 1'b1; // R9
        buf_full_nxt = 1'b0;
      end else begin
        busy_nxt = 1'b0;
        run_burst_nxt = 1'b0;
      end
    end
    if (launch_ok) begin
      blank_nxt = 1'b0; // R14
      if (!busy_nxt) begin
        req_nxt = pend_r;
        start_nxt = 1'b1;
        busy_nxt = 1'b1;
        run_burst_nxt = is_burst;
      end else begin
        buf_nxt = pend_r; // R10
        buf_full_nxt = 1'b1;
      end
    end
    if (stop_abort) begin
      busy_nxt = 1'b0; // R13
      run_burst_nxt = 1'b0;
      buf_full_nxt = 1'b0;
      start_nxt = 1'b0;
      accerr_nxt = 1'b1;
    end
  end
  // protect byte caught on the first edge after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prot_r <= `PROT_RESET;
      prot_loaded_r <= 1'b0;
    end else if (!prot_loaded_r) begin
      prot_r <= stored_protect_byte; // R4
      prot_loaded_r <= 1'b1;
    end else begin
      prot_r <= prot_nxt; // R5
    end
  end
  // software-visible registers and flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_r <= 1'b0;
      cfg_r <= `CFG_RESET;
      div_r <= `DIV_RESET;
      div_loaded_r <= 1'b0;
      cmd_r <= 8'h00;
      pviol_r <= 1'b0;
      accerr_r <= 1'b0;
      blank_r <= 1'b0; // R19
    end else begin
      hresp_r <= 1'b0; // no error answer exists on this slave
      cfg_r <= cfg_nxt;
      div_r <= div_nxt;
      div_loaded_r <= div_loaded_nxt;
      cmd_r <= cmd_nxt;
      pviol_r <= pviol_nxt;
      accerr_r <= accerr_nxt;
      blank_r <= blank_nxt;
    end
  end
  // sequencer, engine hand-off and key compare strobes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_r <= SEQ_IDLE;
      pend_r <= '0;
      buf_r <= '0;
      req_r <= '0;
      busy_r <= 1'b0; // R19
      run_burst_r <= 1'b0;
      buf_full_r <= 1'b0;
      start_r <= 1'b0;
      abort_r <= 1'b0;
      key_wr_r <= 1'b0;
      key_info_r <= '0;
    end else begin
      seq_r <= seq_nxt;
      pend_r <= pend_nxt;
      buf_r <= buf_nxt;
      req_r <= req_nxt;
      busy_r <= busy_nxt;
      run_burst_r <= run_burst_nxt;
      buf_full_r <= buf_full_nxt;
      start_r <= start_nxt;
      abort_r <= stop_abort;
      // key comparison writes go straight out, one cycle later
      key_wr_r <= key_hit; // R3
      if (key_hit) begin
        key_info_r <= '{index: arr_wr_addr[2:0], data: arr_wr_data};
      end
    end
  end
  // ************************************************************
  // read path
  // ************************************************************
  wire logic [7:0] stat_byte = {cbe, ccf, pviol_r, accerr_r, 1'b0, blank_r, 2'b00}; // R8 R11
  logic [7:0] rd_byte;
  // unmapped offsets read zero
  always_comb begin
    unique case (rd_addr_r)
      `OFS_CONFIG: rd_byte = cfg_r; // R1
      `OFS_PROTECT: rd_byte = prot_r; // R5
      `OFS_STATUS: rd_byte = stat_byte;
      `OFS_COMMAND: rd_byte = cmd_r;
      `OFS_CLKDIV: rd_byte = {div_loaded_r, div_r};
      default: rd_byte = 8'h00;
    endcase
  end
  // read data caught in the wait state, held until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_pend_r) begin
      hrdata_r <= {24'h00_0000, rd_byte};
    end
  end
  // ************************************************************
  // outputs
  // ************************************************************
  // each output is a flop or one bit of a flop, no extra copies
  assign hreadyout = ready_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;
  assign eng_start = start_r;
  assign eng_req = req_r;
  assign eng_abort = abort_r;
  assign key_wr = key_wr_r;
  assign key_wr_info = key_info_r;
  assign array_read_invalid = cfg_r[`CFG_KEY_WRITE_SELECT_BIT]; // R3
  assign fclk_div = div_r;
  // ************************************************************
  // assertions
  // ************************************************************
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_CFG_LOW_ZERO: assert property (rd_pend_r && rd_addr_r == `OFS_CONFIG |=> // R1
    hrdata_r[4:0] == 5'h00) else $error("config low bits not zero");
  AST_KEY_CLEAR_CMD: assert property (arr_wr && !key_write_select && cbe && seq_r == SEQ_IDLE // R2
    |=> !key_wr_r && seq_r == SEQ_ADDR) else $error("key area write not a command step");
  AST_KEY_WRITE: assert property (arr_wr && key_write_select && in_key_win |=> // R3
    key_wr_r && key_info_r.data == $past(arr_wr_data)) else $error("key write lost");
  AST_PROT_LOAD: assert property (prot_loaded_r && !$past(prot_loaded_r) |-> // R4
    prot_r == $past(stored_protect_byte)) else $error("protect byte not loaded");
  AST_PROT_RO: assert property (wr_en && wr_addr_r == `OFS_PROTECT && !dbg_prot_wr // R5
    && prot_loaded_r |=> $stable(prot_r)) else $error("bus write changed protect");
  AST_PVIOL: assert property (launch_viol |=> pviol_r && !start_r ##1 // R12
    !start_r) else $error("protected command not dropped");
  AST_STATUS_ZERO: assert property (rd_pend_r && rd_addr_r == `OFS_STATUS |=> // R8
    hrdata_r[3] == 1'b0 && hrdata_r[1:0] == 2'b00) else $error("status reserved bits set");
  AST_BAD_CODE: assert property (launch && seq_r == SEQ_CMD && !code_ok |=> // R17
    accerr_r && !start_r) else $error("illegal code not rejected");
  AST_LAUNCH_CCF: assert property (launch_ok && !stop_req |=> !ccf) // R11
    else $error("complete flag stayed set after launch");
  AST_DIV_GATE: assert property (launch && prog_erase && !div_loaded_r |=> // R18
    accerr_r && !start_r) else $error("program ran before divider load");
  AST_BUF_ONLY_BURST: assert property (busy_r && !run_burst_r |-> !buf_full_r && !cbe) // R10
    else $error("buffer open during non-burst command");
  AST_BLANK_CLEAR: assert property (launch_ok && !(eng_done && busy_r) |=> // R14
    !blank_r) else $error("blank flag kept after new command");
endmodule

// >>> bench/flash_cmd_status_protect_tb.sv
/*
  Self-checking bench of the flash command, status and protection block:
  an AHB-Lite master task, array-write, engine and stop strobes, and call
  sequences with expected register values.
  Assumes the defines header and the package are compiled ahead of it.
*/
`timescale 1ns/1ps
`include "flash_defs.svh"

module flash_cmd_status_protect_tb;
  import flash_pkg::*;

  // ************************************************************
  // signals
  // ************************************************************
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic arr_wr = 1'b0;
  logic [15:0] arr_wr_addr = 16'h0;
  logic [7:0] arr_wr_data = 8'h00;
  logic [7:0] stored_protect_byte = 8'h02;
  logic dbg_prot_wr = 1'b0;
  logic [7:0] dbg_prot_data = 8'h00;
  logic stop_req = 1'b0;
  logic eng_done = 1'b0;
  logic eng_blank = 1'b0;
  logic eng_start;
  eng_req_t eng_req;
  eng_req_t last_req;
  logic eng_abort;
  logic key_wr;
  key_wr_t key_wr_info;
  key_wr_t last_key;
  logic array_read_invalid;
  logic [6:0] fclk_div;
  int bad_count = 0;
  int compares = 0;
  int starts = 0;
  int keys = 0;
  int aborts = 0;
  int cycles = 0;
  int i;
  logic [7:0] codes [5] = '{`CMD_BLANK, `CMD_BYTE_PROG, `CMD_BURST_PROG,
                            `CMD_PAGE_ERASE, `CMD_MASS_ERASE};
  logic [31:0] q;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  always #10 hclk = ~hclk;

  flash_cmd_status_protect flash_cmd_status_protect_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .arr_wr(arr_wr),
    .arr_wr_addr(arr_wr_addr),
    .arr_wr_data(arr_wr_data),
    .stored_protect_byte(stored_protect_byte),
    .dbg_prot_wr(dbg_prot_wr),
    .dbg_prot_data(dbg_prot_data),
    .stop_req(stop_req),
    .eng_done(eng_done),
    .eng_blank(eng_blank),
    .eng_start(eng_start),
    .eng_req(eng_req),
    .eng_abort(eng_abort),
    .key_wr(key_wr),
    .key_wr_info(key_wr_info),
    .array_read_invalid(array_read_invalid),
    .fclk_div(fclk_div)
  );

  // ************************************************************
  // pulse monitors and timeout
  // ************************************************************
  // pulses are counted so no test has to guess their exact cycle
  always @(posedge hclk) begin
    cycles++;
    if (eng_start === 1'b1) begin
      starts++;
      last_req = eng_req;
    end
    if (key_wr === 1'b1) begin
      keys++;
      last_key = key_wr_info;
    end
    if (eng_abort === 1'b1) aborts++;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one single word transfer; read data taken at the last ready edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(name, q, {24'h0, exp});
    chk("hresp", hresp, 32'h0);
  endtask

  task automatic arr(input logic [15:0] a, input logic [7:0] d);
    @(posedge hclk);
    arr_wr <= 1'b1;
    arr_wr_addr <= a;
    arr_wr_data <= d;
    @(posedge hclk);
    arr_wr <= 1'b0;
  endtask

  // full command sequence: array write, code, launch
  task automatic launch(input logic [15:0] a, input logic [7:0] c, input logic [7:0] d);
    arr(a, d);
    wr(`OFS_COMMAND, c);
    wr(`OFS_STATUS, 8'h80);
    repeat (2) @(posedge hclk);
  endtask

  task automatic fin(input logic b);
    @(posedge hclk);
    eng_done <= 1'b1;
    eng_blank <= b;
    @(posedge hclk);
    eng_done <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask

  task automatic stop_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd("status", `OFS_STATUS, 8'hC0);
    rd("config", `OFS_CONFIG, 8'h00);
    rd("protect", `OFS_PROTECT, 8'h02);
    wr(`OFS_PROTECT, 8'hFF);
    rd("protect", `OFS_PROTECT, 8'h02);
    wr(`OFS_STATUS, 8'h4F);
    rd("status", `OFS_STATUS, 8'hC0);
    // key write mode: key window goes to the comparator only
    wr(`OFS_CONFIG, 8'hFF);
    rd("config", `OFS_CONFIG, 8'hE0);
    chk("read_invalid", array_read_invalid, 1'b1);
    arr(16'hFFB3, 8'h5A);
    repeat (2) @(posedge hclk);
    chk("key_count", keys, 1);
    chk("key_info", last_key, {3'd3, 8'h5A});
    wr(`OFS_CONFIG, 8'h00);
    @(posedge hclk);
    chk("read_invalid", array_read_invalid, 1'b0);
    // program before the divider is written
    launch(16'h0100, `CMD_BYTE_PROG, 8'h11);
    rd("status", `OFS_STATUS, 8'hD0);
    chk("starts", starts, 0);
    wr(`OFS_STATUS, 8'h10);
    rd("status", `OFS_STATUS, 8'hC0);
    wr(`OFS_CLKDIV, 8'h05);
    rd("divider", `OFS_CLKDIV, 8'h85);
    chk("fclk_div", fclk_div, 7'h05);
    // illegal code, then a launch with no array write
    launch(16'h0100, 8'h33, 8'h11);
    rd("status", `OFS_STATUS, 8'hD0);
    wr(`OFS_STATUS, 8'h10);
    wr(`OFS_COMMAND, `CMD_BYTE_PROG);
    wr(`OFS_STATUS, 8'h80);
    rd("status", `OFS_STATUS, 8'hD0);
    wr(`OFS_STATUS, 8'h10);
    // protected targets: high block and mass erase
    launch(16'hF000, `CMD_BYTE_PROG, 8'h11);
    rd("status", `OFS_STATUS, 8'hE0);
    wr(`OFS_STATUS, 8'h20);
    launch(16'h0100, `CMD_MASS_ERASE, 8'h11);
    rd("status", `OFS_STATUS, 8'hE0);
    wr(`OFS_STATUS, 8'h20);
    rd("status", `OFS_STATUS, 8'hC0);
    chk("starts", starts, 0);
    // unprotected low block runs
    launch(16'h0100, `CMD_BYTE_PROG, 8'h3C);
    chk("starts", starts, 1);
    chk("req", last_req, {`CMD_BYTE_PROG, 16'h0100, 8'h3C});
    rd("status", `OFS_STATUS, 8'h00);
    fin(1'b0);
    rd("status", `OFS_STATUS, 8'hC0);
    // debug opens protection; every code via the key window
    @(posedge hclk);
    dbg_prot_wr <= 1'b1;
    dbg_prot_data <= 8'h01;
    @(posedge hclk);
    dbg_prot_wr <= 1'b0;
    rd("protect", `OFS_PROTECT, 8'h01);
    for (i = 0; i < 5; i++) begin
      launch(16'hFFB0 + 16'(i), codes[i], 8'hA0 + 8'(i));
      chk("starts", starts, 2 + i);
      chk("req", last_req, {codes[i], 16'hFFB0 + 16'(i), 8'hA0 + 8'(i)});
      rd("status", `OFS_STATUS, (i == 2) ? 8'h80 : 8'h00);
      fin(1'b1);
      rd("status", `OFS_STATUS, (i == 0) ? 8'hC4 : 8'hC0);
    end
    chk("key_count", keys, 1);
    // burst: one queued behind a running one; byte program refused
    launch(16'h0200, `CMD_BURST_PROG, 8'h01);
    rd("status", `OFS_STATUS, 8'h80);
    launch(16'h0202, `CMD_BURST_PROG, 8'h02);
    rd("status", `OFS_STATUS, 8'h00);
    chk("starts", starts, 7);
    fin(1'b0);
    chk("starts", starts, 8);
    chk("req", last_req, {`CMD_BURST_PROG, 16'h0202, 8'h02});
    rd("status", `OFS_STATUS, 8'h80);
    launch(16'h0300, `CMD_BYTE_PROG, 8'h03);
    rd("status", `OFS_STATUS, 8'h90);
    chk("starts", starts, 8);
    fin(1'b0);
    wr(`OFS_STATUS, 8'h10);
    rd("status", `OFS_STATUS, 8'hC0);
    // stop during a command
    launch(16'h0100, `CMD_PAGE_ERASE, 8'h00);
    @(posedge hclk);
    stop_req <= 1'b1;
    @(posedge hclk);
    stop_req <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("aborts", aborts, 1);
    rd("status", `OFS_STATUS, 8'hD0);
    // second reset reloads protection from the stored byte
    stored_protect_byte <= 8'h07;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd("protect", `OFS_PROTECT, 8'h07);
    rd("divider", `OFS_CLKDIV, 8'h00);
    rd("status", `OFS_STATUS, 8'hC0);
    rd("unmapped", 8'h20, 8'h00);
    stop_test();
  end

endmodule
